// *** verilog/isc_cfg.svh ***
// Constants of the SCL timing and general-call status slice: register byte
// addresses, reset values, lower limits, status bit positions, buffer size.
// Assumes it is included by bare name from any file that needs a figure.
`ifndef ISC_CFG_SVH
`define ISC_CFG_SVH

// Register byte addresses on the host bus
`define ISC_ADR_CTRL 32'h50001300
`define ISC_ADR_RXDATA 32'h50001310
`define ISC_ADR_STD_LOW 32'h50001318
`define ISC_ADR_FAST_HIGH 32'h5000131C
`define ISC_ADR_FAST_LOW 32'h50001320
`define ISC_ADR_STATUS 32'h5000132C
`define ISC_ADR_CLR_START 32'h50001364
`define ISC_ADR_CLR_GCALL 32'h50001368
`define ISC_ADR_ENABLE 32'h5000136C

// Reset values and lowest storable values of the period counts
`define ISC_RST_STD_LOW 16'h004F
`define ISC_RST_FAST_HIGH 16'h0008
`define ISC_RST_FAST_LOW 16'h0017
`define ISC_MIN_STD_LOW 16'h0008
`define ISC_MIN_FAST_HIGH 16'h0006
`define ISC_MIN_FAST_LOW 16'h0008

// Status bit positions
`define ISC_BIT_GCALL 11
`define ISC_BIT_START 10

// General call address byte (address 0, write)
`define ISC_GCALL_BYTE 8'h00

// Receive buffer shape
`define ISC_RX_W 8
`define ISC_RX_AW 3
`define ISC_RX_DEPTH 4'h8

`endif

// *** verilog/isc_pkg.sv ***
// Types shared by the SCL timing and general-call status slice.
// Assumes nothing of its surroundings.
package isc_pkg;

    // Speed selection held in the control register
    typedef enum logic [1:0] {
        ISC_SPD_STD,
        ISC_SPD_FAST,
        ISC_SPD_HIGH
    } isc_speed_t;

    // SCL generator states
    typedef enum logic [1:0] {
        ISC_SCL_IDLE,
        ISC_SCL_HIGH,
        ISC_SCL_LOW
    } isc_scl_st_t;

    // Bus-facing receiver states
    typedef enum logic [1:0] {
        ISC_LNK_IDLE,
        ISC_LNK_ADDR,
        ISC_LNK_DATA,
        ISC_LNK_ACK
    } isc_lnk_st_t;

endpackage

// *** verilog/isc_rx_mem.sv ***
// Small receive buffer memory: one write port, one read port whose data
// come out of a register. Assumes the caller manages pointers and levels.
`timescale 1ns/10ps
`include "isc_cfg.svh"

module isc_rx_mem (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Write side
    input wire logic we,
    input wire logic [`ISC_RX_AW-1:0] waddr,
    input wire logic [`ISC_RX_W-1:0] wdata,
    // Read side
    input wire logic [`ISC_RX_AW-1:0] raddr,
    output logic [`ISC_RX_W-1:0] rdata
);

    logic [`ISC_RX_W-1:0] mem [0:(1<<`ISC_RX_AW)-1];

    // Array has no reset; contents are only read once written
    always_ff @(posedge clock) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Forward a write to the word being read so an empty buffer shows it at once
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rdata <= 8'h00;
        end else if (we && (waddr == raddr)) begin
            rdata <= wdata;
        end else begin
            rdata <= mem[raddr];
        end
    end

endmodule

// *** verilog/isc_core.sv ***
// SCL period counts, SCL generator, general-call receiver and status flags.
// Assumes an APB host on clock and an I2C bus whose filter clock is link_clk;
// the standard-speed high count and the run request come from the controller.
`timescale 1ns/10ps
`include "isc_cfg.svh"

module isc_core (
    // System clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Bus filter clock
    input wire logic link_clk,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // From the rest of the controller
    input wire logic [15:0] std_scl_high_count,
    input wire logic scl_run,
    // I2C pins, output enables low while driving
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe_n,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n
);

    // Keeps a change once the second and third stages agree
    function automatic logic isc_filt(input logic [2:0] s, input logic f);
        return (s[1] == s[2]) ? s[2] : f;
    endfunction

    // Lower limit applied to a count written by software
    function automatic logic [15:0] isc_clamp(input logic [15:0] v, input logic [15:0] lo);
        return (v < lo) ? lo : v;
    endfunction

    typedef struct packed {
        logic [15:0] std_scl_low_count;
        logic [15:0] fast_scl_high_count;
        logic [15:0] fast_scl_low_count;
        logic en;
        isc_pkg::isc_speed_t speed;
        logic general_call_seen_flag;
        logic start_condition_flag;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [2:0] gc_s;
        logic gc_f;
        logic [2:0] st_s;
        logic st_f;
        logic [2:0] rq_s;
        logic rq_f;
        logic [`ISC_RX_AW-1:0] wp;
        logic [`ISC_RX_AW-1:0] rp;
        logic [3:0] level;
        isc_pkg::isc_scl_st_t scl_st;
        logic [15:0] scl_cnt;
        logic scl_oe_n;
        logic scl_out;
    } isc_sys_t;

    typedef struct packed {
        logic [2:0] scl_s;
        logic scl_f;
        logic [2:0] sda_s;
        logic sda_f;
        logic [2:0] en_s;
        logic en_f;
        isc_pkg::isc_lnk_st_t st;
        logic [3:0] bits;
        logic [7:0] shift;
        logic [7:0] rx_byte;
        logic gc_tog;
        logic st_tog;
        logic rq_tog;
        logic sda_oe_n;
        logic sda_out;
    } isc_lnk_t;

    isc_sys_t s;
    isc_sys_t next_s;
    isc_lnk_t l;
    isc_lnk_t next_l;
    logic [7:0] mem_rdata;
    logic apb_rd;
    logic apb_wr;
    logic gc_ev;
    logic st_ev;
    logic rq_ev;
    logic push;
    logic pop;
    logic [15:0] hcnt;
    logic [15:0] lcnt;

    // Buffer memory; read address is the next read pointer so data are ready
    isc_rx_mem u_rx_mem (
        .clock(clock),
        .reset_n(reset_n),
        .we(push),
        .waddr(s.wp),
        .wdata(l.rx_byte),
        .raddr(next_s.rp),
        .rdata(mem_rdata)
    );

    // System domain: registers, flags, buffer pointers, SCL generator
    always_comb begin
        next_s = s;
        apb_rd = psel && penable && !pwrite;
        apb_wr = psel && penable && pwrite;
        // Toggles from the bus side; rx_byte is loaded with rq_tog and is stable long before rq_f moves
        next_s.gc_s = {s.gc_s[1:0], l.gc_tog};
        next_s.st_s = {s.st_s[1:0], l.st_tog};
        next_s.rq_s = {s.rq_s[1:0], l.rq_tog};
        next_s.gc_f = isc_filt(s.gc_s, s.gc_f);
        next_s.st_f = isc_filt(s.st_s, s.st_f);
        next_s.rq_f = isc_filt(s.rq_s, s.rq_f);
        gc_ev = next_s.gc_f != s.gc_f;
        st_ev = next_s.st_f != s.st_f;
        rq_ev = next_s.rq_f != s.rq_f;
        // Register writes; speed and counts are locked while enabled
        if (apb_wr) begin
            if (paddr == `ISC_ADR_ENABLE) begin
                next_s.en = pwdata[0];
            end else if (paddr == `ISC_ADR_CTRL && !s.en) begin
                next_s.speed = isc_pkg::isc_speed_t'(pwdata[1:0]);
            end else if (paddr == `ISC_ADR_STD_LOW && !s.en) begin
                next_s.std_scl_low_count = isc_clamp(pwdata[15:0], `ISC_MIN_STD_LOW);
            end else if (paddr == `ISC_ADR_FAST_HIGH && !s.en) begin
                next_s.fast_scl_high_count = isc_clamp(pwdata[15:0], `ISC_MIN_FAST_HIGH);
            end else if (paddr == `ISC_ADR_FAST_LOW && !s.en) begin
                next_s.fast_scl_low_count = isc_clamp(pwdata[15:0], `ISC_MIN_FAST_LOW);
            end
        end
        if (apb_rd && paddr == `ISC_ADR_CLR_GCALL) begin
            next_s.general_call_seen_flag = 1'b0;
        end
        if (apb_rd && paddr == `ISC_ADR_CLR_START) begin
            next_s.start_condition_flag = 1'b0;
        end
        if (gc_ev) begin
            next_s.general_call_seen_flag = 1'b1;
        end
        if (st_ev) begin
            next_s.start_condition_flag = 1'b1;
        end
        if (!s.en) begin
            next_s.general_call_seen_flag = 1'b0;
            next_s.start_condition_flag = 1'b0;
        end
        // bytes into buffer, dropped when full
        pop = apb_rd && paddr == `ISC_ADR_RXDATA && s.level != 4'h0;
        push = rq_ev && s.en && s.level != `ISC_RX_DEPTH;
        if (push) begin
            next_s.wp = s.wp + 3'h1;
        end
        if (pop) begin
            next_s.rp = s.rp + 3'h1;
        end
        next_s.level = s.level + {3'h0, push} - {3'h0, pop};
        // Read data and error are set up in the setup phase and held through access
        next_s.pready = 1'b1;
        if (psel && !penable) begin
            next_s.pslverr = 1'b0;
            next_s.prdata = 32'h00000000;
            if (paddr == `ISC_ADR_ENABLE) begin
                next_s.prdata = {31'h00000000, s.en};
            end else if (paddr == `ISC_ADR_CTRL) begin
                next_s.prdata = {30'h00000000, s.speed};
            end else if (paddr == `ISC_ADR_RXDATA) begin
                next_s.prdata = (s.level != 4'h0) ? {24'h000000, mem_rdata} : 32'h00000000;
            end else if (paddr == `ISC_ADR_STD_LOW) begin
                next_s.prdata = {16'h0000, s.std_scl_low_count};
            end else if (paddr == `ISC_ADR_FAST_HIGH) begin
                next_s.prdata = {16'h0000, s.fast_scl_high_count};
            end else if (paddr == `ISC_ADR_FAST_LOW) begin
                next_s.prdata = {16'h0000, s.fast_scl_low_count};
            end else if (paddr == `ISC_ADR_STATUS) begin
                next_s.prdata[`ISC_BIT_GCALL] = s.general_call_seen_flag;
                next_s.prdata[`ISC_BIT_START] = s.start_condition_flag;
            end else if (paddr == `ISC_ADR_CLR_GCALL) begin
                next_s.prdata = {31'h00000000, s.general_call_seen_flag};
            end else if (paddr == `ISC_ADR_CLR_START) begin
                next_s.prdata = {31'h00000000, s.start_condition_flag};
            end else begin
                next_s.pslverr = 1'b1;
            end
        end
        hcnt = (s.speed == isc_pkg::ISC_SPD_FAST || s.speed == isc_pkg::ISC_SPD_HIGH) ?
            s.fast_scl_high_count : std_scl_high_count;
        lcnt = (s.speed == isc_pkg::ISC_SPD_FAST || s.speed == isc_pkg::ISC_SPD_HIGH) ?
            s.fast_scl_low_count : s.std_scl_low_count;
        next_s.scl_out = 1'b0;
        case (s.scl_st)
            isc_pkg::ISC_SCL_IDLE: begin
                next_s.scl_oe_n = 1'b1;
                if (scl_run && s.en) begin
                    next_s.scl_st = isc_pkg::ISC_SCL_HIGH;
                    next_s.scl_cnt = hcnt - 16'h0001;
                end
            end
            isc_pkg::ISC_SCL_HIGH: begin
                if (s.scl_cnt == 16'h0000) begin
                    next_s.scl_st = isc_pkg::ISC_SCL_LOW;
                    next_s.scl_cnt = lcnt - 16'h0001;
                    next_s.scl_oe_n = 1'b0;
                end else begin
                    next_s.scl_cnt = s.scl_cnt - 16'h0001;
                end
            end
            default: begin
                if (s.scl_cnt != 16'h0000) begin
                    next_s.scl_cnt = s.scl_cnt - 16'h0001;
                end else if (scl_run && s.en) begin
                    next_s.scl_st = isc_pkg::ISC_SCL_HIGH;
                    next_s.scl_cnt = hcnt - 16'h0001;
                    next_s.scl_oe_n = 1'b1;
                end else begin
                    next_s.scl_st = isc_pkg::ISC_SCL_IDLE;
                    next_s.scl_oe_n = 1'b1;
                end
            end
        endcase
    end

    // System register bank; reset values
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0;
            s.std_scl_low_count <= `ISC_RST_STD_LOW;
            s.fast_scl_high_count <= `ISC_RST_FAST_HIGH;
            s.fast_scl_low_count <= `ISC_RST_FAST_LOW;
            s.scl_oe_n <= 1'b1;
            s.speed <= isc_pkg::ISC_SPD_STD;
            s.scl_st <= isc_pkg::ISC_SCL_IDLE;
        end else begin
            s <= next_s;
        end
    end

    // Bus side: filtered pins, start/stop detect, general-call receiver
    always_comb begin
        next_l = l;
        next_l.scl_s = {l.scl_s[1:0], scl_in};
        next_l.sda_s = {l.sda_s[1:0], sda_in};
        next_l.en_s = {l.en_s[1:0], s.en};
        next_l.scl_f = isc_filt(l.scl_s, l.scl_f);
        next_l.sda_f = isc_filt(l.sda_s, l.sda_f);
        next_l.en_f = isc_filt(l.en_s, l.en_f);
        next_l.sda_out = 1'b0;
        if (!l.en_f) begin
            next_l.st = isc_pkg::ISC_LNK_IDLE;
            next_l.sda_oe_n = 1'b1;
        end else if (l.scl_f && next_l.scl_f && l.sda_f && !next_l.sda_f) begin
            next_l.st = isc_pkg::ISC_LNK_ADDR;
            next_l.bits = 4'h0;
            next_l.st_tog = !l.st_tog;
            next_l.sda_oe_n = 1'b1;
        end else if (l.scl_f && next_l.scl_f && !l.sda_f && next_l.sda_f) begin
            next_l.st = isc_pkg::ISC_LNK_IDLE;
            next_l.sda_oe_n = 1'b1;
        end else begin
            case (l.st)
                isc_pkg::ISC_LNK_ADDR, isc_pkg::ISC_LNK_DATA: begin
                    if (!l.scl_f && next_l.scl_f) begin
                        next_l.shift = {l.shift[6:0], next_l.sda_f};
                        next_l.bits = l.bits + 4'h1;
                    end else if (l.scl_f && !next_l.scl_f && l.bits == 4'h8) begin
                        if (l.st == isc_pkg::ISC_LNK_ADDR) begin
                            if (l.shift == `ISC_GCALL_BYTE) begin
                                next_l.st = isc_pkg::ISC_LNK_ACK;
                                next_l.sda_oe_n = 1'b0;
                                next_l.gc_tog = !l.gc_tog;
                            end else begin
                                next_l.st = isc_pkg::ISC_LNK_IDLE;
                            end
                        end else begin
                            next_l.st = isc_pkg::ISC_LNK_ACK;
                            next_l.sda_oe_n = 1'b0;
                            next_l.rx_byte = l.shift;
                            next_l.rq_tog = !l.rq_tog;
                        end
                    end
                end
                isc_pkg::ISC_LNK_ACK: begin
                    // Hold acknowledge through the ninth clock, release on its fall
                    if (l.scl_f && !next_l.scl_f) begin
                        next_l.st = isc_pkg::ISC_LNK_DATA;
                        next_l.sda_oe_n = 1'b1;
                        next_l.bits = 4'h0;
                    end
                end
                default: begin
                    next_l.sda_oe_n = 1'b1;
                end
            endcase
        end
    end

    // Bus-side register bank; filters start at idle-high bus level
    always_ff @(posedge link_clk or negedge reset_n) begin
        if (!reset_n) begin
            l <= '0;
            l.scl_s <= 3'h7;
            l.sda_s <= 3'h7;
            l.scl_f <= 1'b1;
            l.sda_f <= 1'b1;
            l.sda_oe_n <= 1'b1;
            l.st <= isc_pkg::ISC_LNK_IDLE;
        end else begin
            l <= next_l;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign scl_out = s.scl_out;
    assign scl_oe_n = s.scl_oe_n;
    assign sda_out = l.sda_out;
    assign sda_oe_n = l.sda_oe_n;

    // Checks on counts, flags and receiver
    a_std_low_min: assert property (@(posedge clock) disable iff (!reset_n)
        s.std_scl_low_count >= `ISC_MIN_STD_LOW) else $error("std low count below 8");
    a_fast_high_min: assert property (@(posedge clock) disable iff (!reset_n)
        s.fast_scl_high_count >= `ISC_MIN_FAST_HIGH) else $error("fast high below 6");
    a_fast_low_min: assert property (@(posedge clock) disable iff (!reset_n)
        s.fast_scl_low_count >= `ISC_MIN_FAST_LOW) else $error("fast low below 8");
    a_count_lock: assert property (@(posedge clock) disable iff (!reset_n)
        s.en |=> $stable(s.std_scl_low_count) && $stable(s.fast_scl_high_count)
            && $stable(s.fast_scl_low_count)) else $error("count changed while enabled");
    a_gcall_set: assert property (@(posedge clock) disable iff (!reset_n)
        gc_ev && s.en |=> s.general_call_seen_flag ##1 (s.general_call_seen_flag
            || !$past(s.en) || $past(apb_rd))) else $error("general call flag not set");
    a_gcall_clear: assert property (@(posedge clock) disable iff (!reset_n)
        (apb_rd && paddr == `ISC_ADR_CLR_GCALL && !gc_ev) || !s.en
            |=> !s.general_call_seen_flag) else $error("general call flag not cleared");
    a_status_rsvd: assert property (@(posedge clock) disable iff (!reset_n)
        psel && !penable && paddr == `ISC_ADR_STATUS |=> s.prdata[31:12] == 20'h00000)
        else $error("reserved status bits not zero");
    a_fast_timing: assert property (@(posedge clock) disable iff (!reset_n)
        s.scl_st == isc_pkg::ISC_SCL_HIGH && s.scl_cnt == 16'h0000
            && s.speed == isc_pkg::ISC_SPD_HIGH
            |=> s.scl_cnt == s.fast_scl_low_count - 16'h0001 && !s.scl_oe_n)
        else $error("high speed not timed by fast low count");
    a_rx_push: assert property (@(posedge clock) disable iff (!reset_n)
        rq_ev && s.en && s.level == 4'h0 |=> s.level == 4'h1) else $error("byte not buffered");
    a_start_addr: assert property (@(posedge link_clk) disable iff (!reset_n)
        l.en_f && l.scl_f && next_l.scl_f && l.sda_f && !next_l.sda_f
            |=> l.st == isc_pkg::ISC_LNK_ADDR && l.st_tog != $past(l.st_tog))
        else $error("start not detected");

endmodule

// *** testbench/isc_i2c_master.sv ***
// Behavioural I2C master: start, bytes MSB first, acknowledge sampling, stop.
// Assumes the bench resolves each open-drain wire from every enable, pulled up.
`timescale 1ns/10ps

module isc_i2c_master (
    // Drive enables, low while pulling the line down
    output logic scl_oe_n,
    output logic sda_oe_n,
    // Resolved data wire
    input wire logic sda_line
);
    // Slow bit time keeps bytes far apart for the slave's pin filters
    localparam int HALF = 2000;

    // Both lines released at time zero
    initial begin
        scl_oe_n = 1'b1;
        sda_oe_n = 1'b1;
    end

    // SDA falls while SCL is high, then SCL is taken low
    task automatic start_cond();
        sda_oe_n = 1'b0;
        #HALF scl_oe_n = 1'b0;
    endtask

    // Data changes only while SCL is low; ninth pulse reads the acknowledge
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            #(HALF/2) sda_oe_n = b[i];
            #(HALF/2) scl_oe_n = 1'b1;
            #HALF scl_oe_n = 1'b0;
        end
        #(HALF/2) sda_oe_n = 1'b1;
        #(HALF/2) scl_oe_n = 1'b1;
        #(HALF/2) ack = ~sda_line;
        #(HALF/2) scl_oe_n = 1'b0;
    endtask

    // SDA rises while SCL is high
    task automatic stop_cond();
        #(HALF/2) sda_oe_n = 1'b0;
        #(HALF/2) scl_oe_n = 1'b1;
        #HALF sda_oe_n = 1'b1;
        #HALF;
    endtask
endmodule

// *** testbench/isc_core_tb.sv ***
// Self-checking bench: register accesses, SCL timing and general-call flags.
// Assumes isc_core and the behavioural master share pulled-up SCL and SDA.
`timescale 1ns/10ps
`include "isc_cfg.svh"

`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
    $display("[FAIL] %0t got %h expected %h", $time, g, e); end end

module isc_core_tb;
    logic clock = 1'b0, link_clk = 1'b0, reset_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, scl_run = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
    logic pready, pslverr, scl_out, scl_oe_n, sda_out, sda_oe_n, m_scl_n, m_sda_n;
    logic [15:0] std_scl_high_count = 16'h000C;
    logic scl_w, sda_w, ack;
    logic [31:0] rd_d;
    logic rd_e;
    int n_fail = 0, n_compared = 0, cyc = 0;

    // Open-drain wires with pull-ups
    assign scl_w = (scl_oe_n | scl_out) & m_scl_n;
    assign sda_w = (sda_oe_n | sda_out) & m_sda_n;

    isc_core isc_core_i (.clock(clock), .reset_n(reset_n), .link_clk(link_clk),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .std_scl_high_count(std_scl_high_count), .scl_run(scl_run),
        .scl_in(scl_w), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
        .sda_in(sda_w), .sda_out(sda_out), .sda_oe_n(sda_oe_n));

    isc_i2c_master isc_i2c_master_i (.scl_oe_n(m_scl_n), .sda_oe_n(m_sda_n),
        .sda_line(sda_w));

    // Two unrelated clocks
    initial forever #20 clock = ~clock;
    initial begin
        #1.7;
        forever #3 link_clk = ~link_clk;
    end

    // One APB transfer, an idle cycle before it so no strobe toggles twice at once
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clock);
        #1 psel = 1'b1;
        pwrite = w;
        paddr = a;
        pwdata = wd;
        @(posedge clock);
        #1 penable = 1'b1;
        do begin @(posedge clock); n++; end while (pready !== 1'b1 && n < 16);
        rd_d = prdata;
        rd_e = pslverr;
        #1 psel = 1'b0;
        penable = 1'b0;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic chk_rd(input logic [31:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        `CHK(rd_d, e)
        `CHK(rd_e, 1'b0)
    endtask

    task automatic wr_chk(input logic [31:0] a, input logic [31:0] d, input logic [15:0] e);
        wr(a, d);
        chk_rd(a, {16'h0000, e});
    endtask

    // Measures one low and one high SCL period in system clock cycles
    task automatic scl_meas(input logic [1:0] spd, input logic [15:0] hi, input logic [15:0] lo);
        int nl, nh, n;
        n = 0;
        nl = 0;
        nh = 0;
        wr(`ISC_ADR_CTRL, {30'h0, spd});
        wr(`ISC_ADR_ENABLE, 32'h1);
        scl_run = 1'b1;
        // Sample 1 ns after each edge so the enable launched there has settled
        while (scl_oe_n !== 1'b0 && n < 400) begin @(posedge clock); #1; n++; end
        while (scl_oe_n === 1'b0 && nl < 400) begin @(posedge clock); #1; nl++; end
        while (scl_oe_n === 1'b1 && nh < 400) begin @(posedge clock); #1; nh++; end
        `CHK(16'(nl), lo)
        `CHK(16'(nh), hi)
        scl_run = 1'b0;
        wr(`ISC_ADR_ENABLE, 32'h0);
        // Let the period under way finish so the next measurement starts from idle
        repeat (40) @(posedge clock);
    endtask

    // Verdict, reached from the main sequence or the hang guard
    task automatic end_of_test();
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Hang guard well above the expected run length
    always @(posedge clock) begin
        cyc++;
        if (cyc == 30000) begin
            n_fail++;
            end_of_test();
        end
    end

    initial begin
        repeat (10) @(posedge clock);
        #1 reset_n = 1'b1;
        chk_rd(`ISC_ADR_STD_LOW, {16'h0, `ISC_RST_STD_LOW});
        chk_rd(`ISC_ADR_FAST_HIGH, {16'h0, `ISC_RST_FAST_HIGH});
        chk_rd(`ISC_ADR_FAST_LOW, {16'h0, `ISC_RST_FAST_LOW});
        chk_rd(`ISC_ADR_STATUS, 32'h0);
        wr_chk(`ISC_ADR_STD_LOW, 32'h0, `ISC_MIN_STD_LOW);
        wr_chk(`ISC_ADR_STD_LOW, 32'h7, `ISC_MIN_STD_LOW);
        wr_chk(`ISC_ADR_STD_LOW, 32'hABCD1234, 16'h1234);
        wr_chk(`ISC_ADR_FAST_HIGH, 32'h5, `ISC_MIN_FAST_HIGH);
        wr_chk(`ISC_ADR_FAST_HIGH, 32'hFFFF, 16'hFFFF);
        wr_chk(`ISC_ADR_FAST_LOW, 32'h7, `ISC_MIN_FAST_LOW);
        wr_chk(`ISC_ADR_FAST_LOW, 32'h9, 16'h0009);
        // Unmapped place answers with an error and zero data
        xfer(1'b0, 32'h50001304, 32'h0);
        `CHK(rd_e, 1'b1)
        `CHK(rd_d, 32'h0)
        // Counts are locked while enabled
        wr(`ISC_ADR_ENABLE, 32'h1);
        wr(`ISC_ADR_FAST_LOW, 32'h40);
        chk_rd(`ISC_ADR_FAST_LOW, 32'h9);
        wr(`ISC_ADR_ENABLE, 32'h0);
        wr_chk(`ISC_ADR_STD_LOW, 32'hA, 16'h000A);
        wr_chk(`ISC_ADR_FAST_HIGH, 32'h7, 16'h0007);
        scl_meas(2'd0, 16'h000C, 16'h000A);
        scl_meas(2'd1, 16'h0007, 16'h0009);
        scl_meas(2'd2, 16'h0007, 16'h0009);
        // Foreign address: start seen, no acknowledge, no general-call flag
        wr(`ISC_ADR_CTRL, 32'h0);
        wr(`ISC_ADR_ENABLE, 32'h1);
        repeat (5) @(posedge clock);
        isc_i2c_master_i.start_cond();
        isc_i2c_master_i.send_byte(8'h42, ack);
        `CHK(ack, 1'b0)
        isc_i2c_master_i.stop_cond();
        repeat (10) @(posedge clock);
        chk_rd(`ISC_ADR_STATUS, 32'h00000400);
        chk_rd(`ISC_ADR_CLR_START, 32'h1);
        // General call followed by one data byte
        isc_i2c_master_i.start_cond();
        isc_i2c_master_i.send_byte(`ISC_GCALL_BYTE, ack);
        `CHK(ack, 1'b1)
        isc_i2c_master_i.send_byte(8'hA5, ack);
        `CHK(ack, 1'b1)
        isc_i2c_master_i.stop_cond();
        repeat (10) @(posedge clock);
        chk_rd(`ISC_ADR_STATUS, 32'h00000C00);
        chk_rd(`ISC_ADR_STATUS, 32'h00000C00);
        chk_rd(`ISC_ADR_RXDATA, 32'h000000A5);
        chk_rd(`ISC_ADR_RXDATA, 32'h0);
        chk_rd(`ISC_ADR_CLR_GCALL, 32'h1);
        chk_rd(`ISC_ADR_STATUS, 32'h00000400);
        // Second call, then disabling clears both flags
        isc_i2c_master_i.start_cond();
        isc_i2c_master_i.send_byte(`ISC_GCALL_BYTE, ack);
        isc_i2c_master_i.stop_cond();
        repeat (10) @(posedge clock);
        chk_rd(`ISC_ADR_STATUS, 32'h00000C00);
        wr(`ISC_ADR_ENABLE, 32'h0);
        repeat (5) @(posedge clock);
        chk_rd(`ISC_ADR_STATUS, 32'h0);
        end_of_test();
    end
endmodule
